// ### hdl/usb_mouse_pkg.sv
// shared constants and types for the mouse bus-state and status logic
package usb_mouse_pkg;
    // clock rate and the bus timing figures, in their own units
    localparam int CLK_MHZ          = 250;
    localparam int RESET_MIN_NS     = 18700;
    localparam int RESET_MAX_US     = 10000;
    localparam int SUSPEND_MIN_US   = 5000;
    localparam int SUSPEND_MAX_US   = 6000;
    localparam int RESUME_MIN_US    = 11450;
    localparam int RESUME_MAX_US    = 12450;
    // least times round up, longest times round down
    localparam int RESET_MIN_CYC    = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_MAX_CYC    = RESET_MAX_US * CLK_MHZ;
    localparam int SUSPEND_MIN_CYC  = SUSPEND_MIN_US * CLK_MHZ;
    localparam int SUSPEND_MAX_CYC  = SUSPEND_MAX_US * CLK_MHZ;
    localparam int RESUME_MIN_CYC   = RESUME_MIN_US * CLK_MHZ;
    localparam int RESUME_MAX_CYC   = RESUME_MAX_US * CLK_MHZ;
    localparam int TMR_W            = 22;

    // setup packet fields
    localparam logic [7:0]  RT_DEV_OUT       = 8'h00;
    localparam logic [7:0]  RT_DEV_IN        = 8'h80;
    localparam logic [7:0]  RT_IF_IN         = 8'h81;
    localparam logic [7:0]  RT_CLASS_IF_OUT  = 8'h21;
    localparam logic [7:0]  REQ_GET_STATUS   = 8'h00;
    localparam logic [7:0]  REQ_CLR_FEATURE  = 8'h01;
    localparam logic [7:0]  REQ_SET_FEATURE  = 8'h03;
    localparam logic [7:0]  REQ_SET_ADDRESS  = 8'h05;
    localparam logic [7:0]  REQ_SET_CONFIG   = 8'h09;
    localparam logic [7:0]  REQ_SET_PROTOCOL = 8'h0b;
    localparam logic [15:0] FEAT_REMOTE_WAKE = 16'h0001;
    localparam logic [15:0] STATUS_LEN       = 16'h0002;
    localparam logic [15:0] MAX_PKT          = 16'h0008;
    localparam int          DEV_STAT_SELF    = 0;
    localparam int          DEV_STAT_RWU     = 1;

    // register port map
    localparam logic [3:0]  REG_STATUS       = 4'h0;
    localparam logic [3:0]  REG_ADDR         = 4'h1;
    localparam logic [3:0]  REG_CTRL         = 4'h2;
    localparam int          CTRL_RWU_BIT     = 0;
    localparam int          STAT_SUSP_BIT    = 2;
    localparam int          STAT_RESUME_BIT  = 3;

    // reset values
    localparam logic        RWU_RST          = 1'b0;
    localparam logic [6:0]  ADDR_RST         = 7'h00;
    localparam logic        PROTO_RST        = 1'b1;

    typedef enum logic [1:0] {
        BUS_ATTACHED   = 2'b00,
        BUS_DEFAULT    = 2'b01,
        BUS_ADDRESSED  = 2'b10,
        BUS_CONFIGURED = 2'b11
    } bus_state_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00,
        PWR_FINISH = 2'b01,
        PWR_SLEEP  = 2'b10,
        PWR_RESUME = 2'b11
    } pwr_state_t;

    typedef struct packed {
        logic [7:0]  bm_req;
        logic [7:0]  b_req;
        logic [15:0] w_value;
        logic [15:0] w_index;
        logic [15:0] w_length;
    } setup_t;

    typedef struct packed {
        logic       valid;
        logic       stall;
        logic [3:0] len;
        logic [7:0] data0;
        logic [7:0] data1;
    } resp_t;
endpackage

// ### hdl/pin_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int W = 3
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // meta_r feeds only the second stage
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // pin_sync
`default_nettype wire

// ### hdl/dur_timer.sv
// saturating count of consecutive cycles a condition holds
`timescale 1ns/100ps
`default_nettype none
module dur_timer
    import usb_mouse_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             run,
    output logic      [TMR_W-1:0] cnt
);
    logic [TMR_W-1:0] cnt_nxt;

    always_comb begin
        if (!run) begin
            cnt_nxt = '0;
        end else if (&cnt) begin
            cnt_nxt = cnt;
        end else begin
            cnt_nxt = cnt + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= '0;
        end else begin
            cnt <= cnt_nxt;
        end
    end
endmodule // dur_timer
`default_nettype wire

// ### hdl/usb_mouse_bus_state_status.sv
// bus reset, suspend, remote resume and status requests of a low-speed mouse
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1: ignore all requests until first bus reset
// R2: SE0 beyond 18.7 us is bus reset
// R3: reset clears address, Default, Report, flush
// R4: reset restores power-on values, state Default
// R5: suspend starts between 5 and 6 ms idle
// R6: may finish current frame before clock stop
// R7: non-idle bus wakes from suspend
// R8: resume only if wakeup enabled and button
// R9: resume signalling lasts 11.45 to 12.45 ms
// R10: host resumes 20 ms, then 10 ms recovery
// R11: device status: bit0 self, bit1 wakeup
// R12: device status accepted in all states; here not in Attached, which answers nothing
// R13: wakeup bit follows set/clear feature
// R14: interface status stalls before Configured
// R15: interface status returns two zero bytes
// R16: device status setup 80 00 ... 02 00
// R17: 00 03 01 sets, 00 01 01 clears wakeup
// R18: reply never exceeds wLength or 8 bytes
// R19: track Attached/Default/Addressed/Configured bus state
// R20: self-powered bit always reads zero
module usb_mouse_bus_state_status
    import usb_mouse_pkg::*;
#(
    parameter int RESET_CYC   = RESET_MIN_CYC,
    parameter int SUSPEND_CYC = SUSPEND_MIN_CYC,
    parameter int RESUME_CYC  = RESUME_MIN_CYC
) (
    input  wire logic                      clock,
    input  wire logic                      rst_b,
    input  wire logic                      dp_in,
    input  wire logic                      dm_in,
    output logic                           dp_o,
    output logic                           dp_oe,
    output logic                           dm_o,
    output logic                           dm_oe,
    input  wire logic                      button_in,
    input  wire logic                      frame_busy,
    input  wire logic                      setup_valid,
    input  wire usb_mouse_pkg::setup_t     setup,
    output usb_mouse_pkg::resp_t           resp,
    output usb_mouse_pkg::bus_state_t      bus_state,
    output logic                     [6:0] dev_addr,
    output logic                           report_proto,
    output logic                           flush_tx,
    output logic                           suspend,
    output logic                           clk_stop,
    input  wire logic                [3:0] reg_addr,
    input  wire logic                [7:0] reg_wdata,
    input  wire logic                      reg_we,
    input  wire logic                      reg_re,
    output logic                     [7:0] reg_rdata
);
    import usb_mouse_pkg::*;

    logic [2:0]       pins_s;
    logic             dp_s;
    logic             dm_s;
    logic             button_s;
    logic             se0;
    logic             line_idle;
    logic             bus_reset;
    logic [TMR_W-1:0] se0_cnt;
    logic [TMR_W-1:0] idle_cnt;
    logic [TMR_W-1:0] res_cnt;

    bus_state_t bus_r, bus_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic       proto_r, proto_nxt;
    logic       rwu_r, rwu_nxt;
    logic       flush_r, flush_nxt;
    resp_t      resp_r, resp_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    pwr_state_t pwr_r, pwr_nxt;
    logic       susp_r, susp_nxt;
    logic       stop_r, stop_nxt;
    logic       kdrv_r, kdrv_nxt;

    pin_sync #(.W(3)) u_sync (
        .clock    (clock),
        .rst_b    (rst_b),
        .async_in ({button_in, dp_in, dm_in}),
        .sync_out (pins_s)
    );

    assign button_s  = pins_s[2];
    assign dp_s      = pins_s[1];
    assign dm_s      = pins_s[0];
    assign se0       = !dp_s && !dm_s;
    // low-speed idle is J: D- high, D+ low
    assign line_idle = !dp_s && dm_s;

    dur_timer u_se0_tmr (
        .clock (clock),
        .rst_b (rst_b),
        .run   (se0),
        .cnt   (se0_cnt)
    );

    dur_timer u_idle_tmr (
        .clock (clock),
        .rst_b (rst_b),
        .run   (line_idle),
        .cnt   (idle_cnt)
    );

    dur_timer u_res_tmr (
        .clock (clock),
        .rst_b (rst_b),
        .run   (pwr_r == PWR_RESUME),
        .cnt   (res_cnt)
    );

    // one pulse per SE0, well short of the 10 ms limit
    assign bus_reset = se0 && (se0_cnt == TMR_W'(RESET_CYC - 1)); // R2

    function automatic logic [3:0] reply_len(input logic [15:0] wl);
        logic [15:0] n;
        n = (wl < STATUS_LEN) ? wl : STATUS_LEN;
        n = (n < MAX_PKT) ? n : MAX_PKT;
        reply_len = n[3:0]; // R18
    endfunction

    // bus state, status requests and register port
    always_comb begin
        bus_nxt   = bus_r;
        addr_nxt  = addr_r;
        proto_nxt = proto_r;
        rwu_nxt   = rwu_r;
        flush_nxt = 1'b0;
        resp_nxt  = '0;
        rdata_nxt = 8'h00;
        if (bus_reset) begin
            bus_nxt   = BUS_DEFAULT; // R4
            addr_nxt  = ADDR_RST; // R3
            proto_nxt = PROTO_RST; // R3
            rwu_nxt   = RWU_RST; // R4
            flush_nxt = 1'b1; // R3
        end else begin
            if (reg_we && reg_addr == REG_CTRL) begin
                rwu_nxt = reg_wdata[CTRL_RWU_BIT];
            end
            // Attached answers nothing, not even a stall
            if (setup_valid && bus_r != BUS_ATTACHED) begin // R1 R19
                case (setup.b_req)
                    REQ_GET_STATUS: begin
                        if (setup.bm_req == RT_DEV_IN) begin // R16
                            resp_nxt.valid = 1'b1; // R12
                            resp_nxt.len   = reply_len(setup.w_length);
                            resp_nxt.data0[DEV_STAT_SELF] = 1'b0; // R20
                            resp_nxt.data0[DEV_STAT_RWU]  = rwu_r; // R11
                        end else if (setup.bm_req == RT_IF_IN) begin
                            resp_nxt.valid = 1'b1;
                            if (bus_r == BUS_CONFIGURED) begin
                                resp_nxt.len = reply_len(setup.w_length); // R15
                            end else begin
                                resp_nxt.stall = 1'b1; // R14
                            end
                        end
                    end
                    REQ_SET_FEATURE, REQ_CLR_FEATURE: begin
                        if (setup.bm_req == RT_DEV_OUT && setup.w_value == FEAT_REMOTE_WAKE) begin
                            rwu_nxt = (setup.b_req == REQ_SET_FEATURE); // R13 R17
                        end
                    end
                    REQ_SET_ADDRESS: begin
                        if (setup.bm_req == RT_DEV_OUT && bus_r != BUS_CONFIGURED) begin
                            addr_nxt = setup.w_value[6:0];
                            bus_nxt  = (setup.w_value[6:0] == 7'h00) ? BUS_DEFAULT : BUS_ADDRESSED; // R19
                        end
                    end
                    REQ_SET_CONFIG: begin
                        if (setup.bm_req == RT_DEV_OUT && bus_r != BUS_DEFAULT) begin
                            bus_nxt = setup.w_value[0] ? BUS_CONFIGURED : BUS_ADDRESSED; // R19
                        end
                    end
                    REQ_SET_PROTOCOL: begin
                        if (setup.bm_req == RT_CLASS_IF_OUT) begin
                            proto_nxt = setup.w_value[0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (reg_re) begin
            case (reg_addr)
                REG_STATUS: begin
                    rdata_nxt[1:0]             = bus_r;
                    rdata_nxt[STAT_SUSP_BIT]   = susp_r;
                    rdata_nxt[STAT_RESUME_BIT] = kdrv_r;
                end
                REG_ADDR: rdata_nxt = {1'b0, addr_r};
                REG_CTRL: rdata_nxt[CTRL_RWU_BIT] = rwu_r;
                default:  rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bus_r   <= BUS_ATTACHED;
            addr_r  <= ADDR_RST;
            proto_r <= PROTO_RST;
            rwu_r   <= RWU_RST;
            flush_r <= 1'b0;
            resp_r  <= '0;
            rdata_r <= 8'h00;
        end else begin
            bus_r   <= bus_nxt;
            addr_r  <= addr_nxt;
            proto_r <= proto_nxt;
            rwu_r   <= rwu_nxt;
            flush_r <= flush_nxt;
            resp_r  <= resp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // power state: suspend entry, frame finish, wake and remote resume
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            PWR_ACTIVE: begin
                if (line_idle && idle_cnt >= TMR_W'(SUSPEND_CYC - 1)) begin
                    pwr_nxt = PWR_FINISH; // R5
                end
            end
            PWR_FINISH: begin
                if (!line_idle) begin
                    pwr_nxt = PWR_ACTIVE; // R7
                end else if (!frame_busy) begin
                    pwr_nxt = PWR_SLEEP; // R6
                end
            end
            PWR_SLEEP: begin
                if (!line_idle) begin
                    pwr_nxt = PWR_ACTIVE; // R7
                end else if (rwu_r && button_s) begin
                    pwr_nxt = PWR_RESUME; // R8
                end
            end
            PWR_RESUME: begin
                // own K on the line is not a wake event
                if (res_cnt >= TMR_W'(RESUME_CYC - 1)) begin
                    pwr_nxt = PWR_ACTIVE; // R9
                end
            end
            default: pwr_nxt = PWR_ACTIVE;
        endcase
        susp_nxt = (pwr_nxt == PWR_FINISH) || (pwr_nxt == PWR_SLEEP);
        stop_nxt = (pwr_nxt == PWR_SLEEP);
        kdrv_nxt = (pwr_nxt == PWR_RESUME);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pwr_r  <= PWR_ACTIVE;
            susp_r <= 1'b0;
            stop_r <= 1'b0;
            kdrv_r <= 1'b0;
        end else begin
            pwr_r  <= pwr_nxt;
            susp_r <= susp_nxt;
            stop_r <= stop_nxt;
            kdrv_r <= kdrv_nxt;
        end
    end

    // K state at low speed: D+ high, D- low
    assign dp_o         = kdrv_r;
    assign dp_oe        = kdrv_r;
    assign dm_o         = 1'b0;
    assign dm_oe        = kdrv_r;
    assign resp         = resp_r;
    assign bus_state    = bus_r;
    assign dev_addr     = addr_r;
    assign report_proto = proto_r;
    assign flush_tx     = flush_r;
    assign suspend      = susp_r;
    assign clk_stop     = stop_r;
    assign reg_rdata    = rdata_r;

    AST_SILENT_ATTACHED: assert property (@(posedge clock) disable iff (!rst_b) // R1
        (bus_r == BUS_ATTACHED && !bus_reset) |=> !resp_r.valid)
        else $error("answer given before first bus reset");

    AST_RESET_AT_THRESHOLD: assert property (@(posedge clock) disable iff (!rst_b) // R2
        $rose(flush_r) |-> $past(se0_cnt) == TMR_W'(RESET_CYC - 1))
        else $error("bus reset taken at wrong SE0 length");

    AST_RESET_EFFECTS: assert property (@(posedge clock) disable iff (!rst_b) // R3
        bus_reset |=> (bus_r == BUS_DEFAULT && addr_r == 7'h00 && proto_r && flush_r))
        else $error("bus reset side effects missing");

    AST_RESET_CLEARS_WAKE: assert property (@(posedge clock) disable iff (!rst_b) // R4
        bus_reset |=> !rwu_r ##1 !flush_r)
        else $error("wakeup enable or flush wrong after bus reset");

    AST_SUSPEND_WINDOW: assert property (@(posedge clock) disable iff (!rst_b) // R5
        $rose(susp_r) |-> ($past(idle_cnt) >= TMR_W'(SUSPEND_CYC - 1)) &&
                          ($past(idle_cnt) <  TMR_W'(SUSPEND_MAX_CYC)))
        else $error("suspend entered outside idle window");

    AST_WAKE_ON_ACTIVITY: assert property (@(posedge clock) disable iff (!rst_b) // R7
        (susp_r && !line_idle) |=> !susp_r)
        else $error("suspend held on a busy bus");

    AST_RESUME_CAUSE: assert property (@(posedge clock) disable iff (!rst_b) // R8
        $rose(kdrv_r) |-> $past(rwu_r && button_s && stop_r))
        else $error("resume without enable and button");

    AST_RESUME_LENGTH: assert property (@(posedge clock) disable iff (!rst_b) // R9
        $fell(kdrv_r) |-> $past(res_cnt) == TMR_W'(RESUME_CYC - 1))
        else $error("resume signalling of wrong length");

    AST_DEV_STATUS: assert property (@(posedge clock) disable iff (!rst_b) // R11
        (setup_valid && !bus_reset && bus_r != BUS_ATTACHED && setup.bm_req == RT_DEV_IN &&
         setup.b_req == REQ_GET_STATUS) |=>
        (resp_r.valid && !resp_r.stall && resp_r.data0 == {6'h00, $past(rwu_r), 1'b0} &&
         resp_r.data1 == 8'h00 && resp_r.len <= 4'h2))
        else $error("device status answer wrong");

    AST_IF_STALL: assert property (@(posedge clock) disable iff (!rst_b) // R14
        (setup_valid && !bus_reset && setup.bm_req == RT_IF_IN && setup.b_req == REQ_GET_STATUS &&
         (bus_r == BUS_DEFAULT || bus_r == BUS_ADDRESSED)) |=> (resp_r.valid && resp_r.stall))
        else $error("interface status not stalled before configuration");

    COV_BUS_RESET: cover property (@(posedge clock) disable iff (!rst_b) bus_reset);
    COV_SLEEP: cover property (@(posedge clock) disable iff (!rst_b) $rose(stop_r));
    COV_REMOTE_RESUME: cover property (@(posedge clock) disable iff (!rst_b) $fell(kdrv_r));
    COV_IF_STALL: cover property (@(posedge clock) disable iff (!rst_b) resp_r.valid && resp_r.stall);
endmodule // usb_mouse_bus_state_status
`default_nettype wire

// ### bench/usb_host_model.sv
// host side of the low-speed bus: line levels for reset, idle, traffic and host resume
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic [1:0] host_cmd,
    input  wire logic       dp_o,
    input  wire logic       dp_oe,
    input  wire logic       dm_o,
    input  wire logic       dm_oe,
    output logic            dp_in,
    output logic            dm_in
);
    logic tog_r;
    logic hp;
    logic hm;

    // traffic flips every cycle so the device never sees a stale idle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tog_r <= 1'b0;
        end else begin
            tog_r <= ~tog_r;
        end
    end

    // cmd 0 released: pull-up on d-, pull-down on d+; 1 se0; 2 traffic; 3 resume k
    assign hp = (host_cmd == 2'd2) ? tog_r : (host_cmd == 2'd3);
    assign hm = (host_cmd == 2'd0) | ((host_cmd == 2'd2) & ~tog_r);
    // device drive wins the wire only while its enable is high
    assign dp_in = dp_oe ? dp_o : hp;
    assign dm_in = dm_oe ? dm_o : hm;
endmodule // usb_host_model
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the mouse bus-state and status block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import usb_mouse_pkg::*;
    localparam int RST_T = 20;
    localparam int SUSP_T = 200;
    localparam int RES_T = 300;
    localparam int LIMIT = 6000;

    logic clock = 1'b0;
    logic rst_b, dp_in, dm_in, dp_o, dp_oe, dm_o, dm_oe, button_in, frame_busy, setup_valid;
    logic report_proto, flush_tx, suspend, clk_stop, reg_we, reg_re;
    logic [1:0] host_cmd;
    logic [6:0] dev_addr;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd;
    setup_t setup;
    resp_t resp;
    bus_state_t bus_state;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int flush_cnt = 0;
    int n, m, fl0;

    always #2 clock = ~clock;

    usb_mouse_bus_state_status #(.RESET_CYC(RST_T), .SUSPEND_CYC(SUSP_T), .RESUME_CYC(RES_T))
    usb_mouse_bus_state_status_i (.clock(clock), .rst_b(rst_b), .dp_in(dp_in), .dm_in(dm_in),
        .dp_o(dp_o), .dp_oe(dp_oe), .dm_o(dm_o), .dm_oe(dm_oe), .button_in(button_in),
        .frame_busy(frame_busy), .setup_valid(setup_valid), .setup(setup), .resp(resp),
        .bus_state(bus_state), .dev_addr(dev_addr), .report_proto(report_proto), .flush_tx(flush_tx),
        .suspend(suspend), .clk_stop(clk_stop), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));

    usb_host_model usb_host_model_i (.clock(clock), .rst_b(rst_b), .host_cmd(host_cmd), .dp_o(dp_o),
        .dp_oe(dp_oe), .dm_o(dm_o), .dm_oe(dm_oe), .dp_in(dp_in), .dm_in(dm_in));

    always @(posedge clock) begin
        if (flush_tx === 1'b1) begin
            flush_cnt++;
        end
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            $display("timeout after %0d cycles", cycles);
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // a stalled reply carries no data, so only its flags and length are compared
    task automatic chk_resp(input string what, input logic st, input logic [3:0] ln, input logic [7:0] d0);
        chk(what, {26'h0, 1'b1, st, ln}, {26'h0, resp.valid, resp.stall, resp.len});
        if (!st) begin
            chk(what, {16'h0, d0, 8'h00}, {16'h0, resp.data0, resp.data1});
        end
    endtask

    task automatic send_setup(input logic [7:0] bm, input logic [7:0] br, input logic [15:0] wv,
                              input logic [15:0] wl);
        @(posedge clock);
        setup_valid <= 1'b1;
        setup <= '{bm_req: bm, b_req: br, w_value: wv, w_index: 16'h0000, w_length: wl};
        @(posedge clock);
        setup_valid <= 1'b0;
        #1;
    endtask

    task automatic get_dev(input logic rwu, input logic [15:0] wl, input logic [3:0] ln);
        send_setup(RT_DEV_IN, REQ_GET_STATUS, 16'h0000, wl);
        chk_resp("device status", 1'b0, ln, {6'h00, rwu, 1'b0});
    endtask

    task automatic get_if(input logic st);
        send_setup(RT_IF_IN, REQ_GET_STATUS, 16'h0000, STATUS_LEN);
        chk_resp("interface status", st, st ? 4'h0 : 4'h2, 8'h00);
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_we <= 1'b0;
        #1;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_re <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // sel 0 suspend up, 1 clk_stop up, 2 drive up, 3 drive down, 4 suspend down
    task automatic wait_on(input int sel, input int max, output int k);
        k = 0;
        while (k < max && !(sel == 0 ? suspend === 1'b1 : sel == 1 ? clk_stop === 1'b1 :
               sel == 2 ? dp_oe === 1'b1 : sel == 3 ? dp_oe === 1'b0 : suspend === 1'b0)) begin
            @(posedge clock);
            #1;
            k++;
        end
    endtask

    // se0 for len cycles; a reset only when len reaches the reset count, as the synchroniser delays both edges
    task automatic bus_reset(input int len);
        @(posedge clock);
        host_cmd <= 2'd1;
        repeat (len) @(posedge clock);
        host_cmd <= 2'd2;
        repeat (4) @(posedge clock);
        #1;
    endtask

    initial begin
        rst_b = 1'b0;
        host_cmd = 2'd2;
        button_in = 1'b0;
        frame_busy = 1'b0;
        setup_valid = 1'b0;
        setup = '0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_we = 1'b0;
        reg_re = 1'b0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        chk("power-up state", BUS_ATTACHED, bus_state);
        chk("power-up protocol", 1, report_proto);
        send_setup(RT_DEV_IN, REQ_GET_STATUS, 16'h0000, STATUS_LEN);
        chk("reply before bus reset", 0, resp.valid);
        fl0 = flush_cnt;
        bus_reset(RST_T - 10);
        chk("short se0 state", BUS_ATTACHED, bus_state);
        chk("short se0 flush", fl0, flush_cnt);
        $display("power-up test done");

        bus_reset(RST_T + 4);
        chk("reset state", BUS_DEFAULT, bus_state);
        chk("reset address", 0, dev_addr);
        chk("reset flush", fl0 + 1, flush_cnt);
        get_dev(1'b0, STATUS_LEN, 4'h2);
        get_if(1'b1);
        send_setup(RT_DEV_OUT, REQ_SET_FEATURE, FEAT_REMOTE_WAKE, 16'h0000);
        get_dev(1'b1, STATUS_LEN, 4'h2);
        reg_read(REG_CTRL, rd);
        chk("ctrl after set", 1, rd);
        send_setup(RT_DEV_OUT, REQ_CLR_FEATURE, FEAT_REMOTE_WAKE, 16'h0000);
        get_dev(1'b0, STATUS_LEN, 4'h2);
        send_setup(RT_DEV_OUT, REQ_SET_ADDRESS, 16'h0005, 16'h0000);
        chk("addressed state", BUS_ADDRESSED, bus_state);
        chk("address", 5, dev_addr);
        get_dev(1'b0, STATUS_LEN, 4'h2);
        get_if(1'b1);
        send_setup(RT_DEV_OUT, REQ_SET_CONFIG, 16'h0001, 16'h0000);
        chk("configured state", BUS_CONFIGURED, bus_state);
        send_setup(RT_DEV_OUT, REQ_SET_ADDRESS, 16'h0009, 16'h0000);
        chk("address kept when configured", 5, dev_addr);
        get_if(1'b0);
        get_dev(1'b0, 16'h0001, 4'h1);
        get_dev(1'b0, 16'h0040, 4'h2);
        send_setup(RT_CLASS_IF_OUT, REQ_SET_PROTOCOL, 16'h0000, 16'h0000);
        chk("boot protocol", 0, report_proto);
        reg_write(REG_CTRL, 8'h01);
        get_dev(1'b1, STATUS_LEN, 4'h2);
        reg_write(4'hf, 8'hff);
        reg_read(4'hf, rd);
        chk("unmapped read", 0, rd);
        reg_write(REG_ADDR, 8'h7f);
        reg_read(REG_ADDR, rd);
        chk("address read-only", 5, rd);
        reg_read(REG_STATUS, rd);
        chk("status register", 8'h03, rd);
        bus_reset(RST_T + 4);
        chk("second reset state", BUS_DEFAULT, bus_state);
        chk("second reset address", 0, dev_addr);
        chk("second reset protocol", 1, report_proto);
        get_dev(1'b0, STATUS_LEN, 4'h2);
        reg_read(REG_CTRL, rd);
        chk("ctrl after reset", 0, rd);
        $display("request test done");

        // idle with a frame in flight: suspend window, then clock stop waits for the frame
        frame_busy <= 1'b1;
        host_cmd <= 2'd0;
        wait_on(0, SUSP_T - 5, n);
        chk("no early suspend", SUSP_T - 5, n);
        wait_on(0, SUSP_T / 5 + 5, m);
        chk("suspend by max", 1, suspend);
        repeat (5) @(posedge clock);
        #1;
        chk("clock held for frame", 0, clk_stop);
        frame_busy <= 1'b0;
        wait_on(1, 3, n);
        chk("clock stop after frame", 1, clk_stop);
        reg_read(REG_STATUS, rd);
        chk("status asleep", 8'h05, rd);
        button_in <= 1'b1;
        repeat (10) @(posedge clock);
        #1;
        chk("no resume when disabled", 0, dp_oe);
        button_in <= 1'b0;
        host_cmd <= 2'd2;
        wait_on(4, 5, n);
        chk("wake on traffic", 0, suspend);
        chk("clock runs after wake", 0, clk_stop);
        $display("suspend test done");

        send_setup(RT_DEV_OUT, REQ_SET_FEATURE, FEAT_REMOTE_WAKE, 16'h0000);
        host_cmd <= 2'd0;
        wait_on(1, SUSP_T + 60, n);
        chk("asleep again", 1, clk_stop);
        button_in <= 1'b1;
        wait_on(2, 6, n);
        chk("resume drive", 1, dp_oe);
        chk("resume k on wire", 2'b10, {dp_in, dm_in});
        reg_read(REG_STATUS, rd);
        chk("status resuming", 8'h09, rd);
        wait_on(3, RES_T + 10, n);
        chk("resume length", RES_T - 2, n);
        button_in <= 1'b0;
        host_cmd <= 2'd3;
        repeat (20) @(posedge clock);
        host_cmd <= 2'd2;
        repeat (4) @(posedge clock);
        #1;
        chk("awake after resume", 0, suspend);
        $display("resume test done");
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
